// *** tpfs_tx_fifo_bser.sv ***
/*
 * Transmit phase compensation FIFO, byte serializer and register port.
 * Assumes clk_i is the parallel clock domain; local, bonded and fabric
 * rates come in as one-cycle enables from same-clock logic.
 */
// Chosen here: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module tpfs_tx_fifo_bser #(
   parameter bit ALLOW_BSER_DW = 1'b0
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic tx_digital_reset_i,
   input wire logic local_par_en_i,
   input wire logic bonded_par_en_i,
   input wire logic tx_core_en_i,
   input wire logic [tpfs_pkg::WORD_W-1:0] tx_data_i,
   input wire logic [3:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [31:0] rdata_o,
   output var tpfs_pkg::tpfs_out_s out_o,
   output logic core_clk_en_o,
   output logic fifo_err_o,
   output logic irq_o
);

   tpfs_pkg::tpfs_cfg_s cfg;
   logic [2:0] status;
   logic [2:0] mask;
   logic [tpfs_pkg::WORD_W-1:0] mem [0:7];
   logic [3:0] wr_ptr;
   logic [3:0] rd_ptr;
   logic [3:0] count;
   tpfs_pkg::tpfs_state_e state;
   logic half_ph;
   logic [tpfs_pkg::WORD_W-1:0] reg_word;
   logic [tpfs_pkg::WORD_W-1:0] ser_word;
   logic eff_dw;
   logic eff_bser;
   logic cfg_bad;
   tpfs_pkg::tpfs_mode_e mode;
   tpfs_pkg::tpfs_dest_e dest;
   logic [3:0] depth;
   logic [3:0] prime;
   logic par_en;
   logic rd_slot;
   logic wr_slot;
   logic rd_fire;
   logic ovf;
   logic unf;
   logic [tpfs_pkg::WORD_W-1:0] rd_word;
   logic [tpfs_pkg::SYM_W-1:0] lo_half;
   logic hi_due;
   logic [tpfs_pkg::SYM_W-1:0] full_sym;
   logic [2:0] stat_set;
   logic [2:0] stat_clr;

   // Configuration decode
   always_comb begin
      eff_dw = cfg.dw && (cfg.proto == tpfs_pkg::PROTO_BASIC ||
                          cfg.proto == tpfs_pkg::PROTO_DETLAT);
      eff_bser = cfg.bser && !(eff_dw && !ALLOW_BSER_DW);
      cfg_bad = (cfg.dw && !eff_dw) || (cfg.bser && !eff_bser);
      case (cfg.proto)
         tpfs_pkg::PROTO_PCIE: mode = tpfs_pkg::MODE_HIGH;
         tpfs_pkg::PROTO_DETLAT: mode = tpfs_pkg::MODE_REG;
         default: mode = tpfs_pkg::MODE_LOW;
      endcase
      depth = (mode == tpfs_pkg::MODE_HIGH) ? tpfs_pkg::HIGH_DEPTH
                                            : tpfs_pkg::LOW_DEPTH;
      prime = (mode == tpfs_pkg::MODE_HIGH) ? tpfs_pkg::HIGH_PRIME
                                            : tpfs_pkg::LOW_PRIME;
      // Encoder takes 8-bit symbols only; bypass always to serializer
      if (cfg.enc && !cfg.byp && !cfg.w10) begin
         dest = tpfs_pkg::DEST_ENC;
      end else begin
         dest = tpfs_pkg::DEST_SER;
      end
   end

   // Rates: read from local or bonded clock, write from core enable with cclk, else from core_clk_en_o
   assign par_en = cfg.bond ? bonded_par_en_i : local_par_en_i;
   assign rd_slot = par_en && (!eff_bser || !half_ph);
   // Equal rates assumed; outside register mode any drift shows as overflow or underflow
   assign wr_slot = cfg.cclk ? tx_core_en_i : core_clk_en_o;
   assign count = wr_ptr - rd_ptr;
   assign rd_fire = rd_slot && state == tpfs_pkg::ST_RUN &&
                    mode != tpfs_pkg::MODE_REG && count != 4'h0;
   // At or above depth, so a switch to a smaller mode cannot overrun
   assign ovf = wr_slot && mode != tpfs_pkg::MODE_REG &&
                count >= depth;
   assign unf = rd_slot && state == tpfs_pkg::ST_RUN &&
                mode != tpfs_pkg::MODE_REG && count == 4'h0;
   assign rd_word = (mode == tpfs_pkg::MODE_REG) ? reg_word
                                                 : mem[rd_ptr[2:0]];

   // Half and full symbols per width setting
   always_comb begin
      case ({eff_dw, cfg.w10})
         2'b00: begin
            lo_half = {12'h000, rd_word[7:0]};
         end
         2'b01: begin
            lo_half = {10'h000, rd_word[9:0]};
         end
         2'b10: begin
            lo_half = {4'h0, rd_word[15:0]};
         end
         default: begin
            lo_half = rd_word[19:0];
         end
      endcase
      case ({eff_dw, cfg.w10})
         2'b00: full_sym = {12'h000, rd_word[7:0]};
         2'b01: full_sym = {10'h000, rd_word[9:0]};
         2'b10: full_sym = {4'h0, rd_word[15:0]};
         default: full_sym = rd_word[19:0];
      endcase
   end

   // FIFO storage; no reset needed on data
   always_ff @(posedge clk_i) begin
      if (wr_slot && !ovf) begin
         mem[wr_ptr[2:0]] <= tx_data_i;
      end
   end

   // Pointers and start control
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wr_ptr <= 4'h0;
         rd_ptr <= 4'h0;
         state <= tpfs_pkg::ST_PRIME;
      end else if (tx_digital_reset_i) begin
         wr_ptr <= 4'h0;
         rd_ptr <= 4'h0;
         state <= tpfs_pkg::ST_PRIME;
      end else begin
         if (wr_slot && !ovf && mode != tpfs_pkg::MODE_REG) begin
            wr_ptr <= wr_ptr + 4'h1;
         end
         if (rd_fire) begin
            rd_ptr <= rd_ptr + 4'h1;
         end
         case (state)
            // Spacing of prime words sets the pass-through latency
            tpfs_pkg::ST_PRIME: begin
               if (mode == tpfs_pkg::MODE_REG || count >= prime) begin
                  state <= tpfs_pkg::ST_RUN;
               end
            end
            tpfs_pkg::ST_RUN: state <= tpfs_pkg::ST_RUN;
            default: state <= tpfs_pkg::ST_PRIME;
         endcase
      end
   end

   // Register stage for fixed-latency mode
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         reg_word <= '0;
      end else if (tx_digital_reset_i) begin
         reg_word <= '0;
      end else if (wr_slot && mode == tpfs_pkg::MODE_REG) begin
         reg_word <= tx_data_i;
      end
   end

   // Byte serializer and output
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         half_ph <= 1'b0;
         hi_due <= 1'b0;
         ser_word <= '0;
         out_o <= '{data: '0, valid: 1'b0, dest: tpfs_pkg::DEST_SER};
         core_clk_en_o <= 1'b0;
      end else if (tx_digital_reset_i) begin
         half_ph <= 1'b0;
         hi_due <= 1'b0;
         ser_word <= '0;
         out_o <= '{data: '0, valid: 1'b0, dest: tpfs_pkg::DEST_SER};
         core_clk_en_o <= 1'b0;
      end else begin
         core_clk_en_o <= rd_slot;
         out_o.valid <= 1'b0;
         out_o.dest <= dest;
         if (par_en && eff_bser) begin
            half_ph <= !half_ph;
         end else if (!eff_bser) begin
            half_ph <= 1'b0;
         end
         // A high half only follows its own low half, never a stale word
         if (rd_fire || (rd_slot && mode == tpfs_pkg::MODE_REG)) begin
            ser_word <= rd_word;
            hi_due <= eff_bser;
            out_o.valid <= 1'b1;
            out_o.data <= eff_bser ? lo_half : full_sym;
         end else if (par_en && eff_bser && hi_due) begin
            hi_due <= 1'b0;
            out_o.valid <= 1'b1;
            case ({eff_dw, cfg.w10})
               2'b00: out_o.data <= {12'h000, ser_word[15:8]};
               2'b01: out_o.data <= {10'h000, ser_word[19:10]};
               2'b10: out_o.data <= {4'h0, ser_word[31:16]};
               default: out_o.data <= ser_word[39:20];
            endcase
         end
      end
   end

   // Error pulse
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         fifo_err_o <= 1'b0;
      end else if (tx_digital_reset_i) begin
         fifo_err_o <= 1'b0;
      end else begin
         fifo_err_o <= ovf || unf;
      end
   end

   // Register port
   always_comb begin
      stat_set = 3'h0;
      stat_set[tpfs_pkg::ST_OVF_BIT] = ovf;
      stat_set[tpfs_pkg::ST_UNF_BIT] = unf;
      stat_set[tpfs_pkg::ST_CFG_BIT] = cfg_bad;
      stat_clr = (wr_i && addr_i == tpfs_pkg::REG_STAT) ? wdata_i[2:0]
                                                        : 3'h0;
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cfg <= tpfs_pkg::CTRL_RST;
         mask <= tpfs_pkg::MASK_RST;
      end else if (wr_i) begin
         if (addr_i == tpfs_pkg::REG_CTRL) begin
            cfg <= wdata_i[8:0];
         end
         if (addr_i == tpfs_pkg::REG_MASK) begin
            mask <= wdata_i[2:0];
         end
      end
   end

   // Set beats clear; digital reset clears the overflow and underflow bits
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         status <= tpfs_pkg::STAT_RST;
      end else if (tx_digital_reset_i) begin
         status <= {(status[2] & ~stat_clr[2]) | stat_set[2],
                    2'b00};
      end else begin
         status <= (status & ~stat_clr) | stat_set;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         irq_o <= 1'b0;
         rdata_o <= 32'h0000_0000;
      end else begin
         irq_o <= |(status & mask);
         rdata_o <= 32'h0000_0000;
         if (rd_i) begin
            case (addr_i)
               tpfs_pkg::REG_CTRL: rdata_o <= {23'h000000, cfg};
               tpfs_pkg::REG_STAT: rdata_o <= {29'h00000000, status};
               tpfs_pkg::REG_MASK: rdata_o <= {29'h00000000, mask};
               tpfs_pkg::REG_LEVEL: begin
                  rdata_o <= {21'h000000, eff_bser, eff_dw, state,
                              mode, count};
               end
               default: rdata_o <= 32'h0000_0000;
            endcase
         end
      end
   end

   // Checks
   sequence s_dreset;
      tx_digital_reset_i;
   endsequence

   sequence s_cleared;
      count == 4'h0 && !fifo_err_o && state == tpfs_pkg::ST_PRIME;
   endsequence

   property p_reset_clears;
      @(posedge clk_i) disable iff (!rst_n_i)
      s_dreset |=> s_cleared;
   endproperty
   a_reset_clears: assert property (p_reset_clears)
      else $error("digital reset left FIFO state");

   property p_err_flag;
      @(posedge clk_i) disable iff (!rst_n_i)
      (ovf || unf) && !tx_digital_reset_i |=> fifo_err_o &&
         (status[tpfs_pkg::ST_OVF_BIT] || status[tpfs_pkg::ST_UNF_BIT]);
   endproperty
   a_err_flag: assert property (p_err_flag)
      else $error("error not flagged");

   property p_low_depth;
      @(posedge clk_i) disable iff (!rst_n_i)
      mode == tpfs_pkg::MODE_LOW && $stable(mode) |-> count <= 4'h4;
   endproperty
   a_low_depth: assert property (p_low_depth)
      else $error("low mode over four words");

   property p_high_depth;
      @(posedge clk_i) disable iff (!rst_n_i)
      mode == tpfs_pkg::MODE_HIGH |-> count <= 4'h8;
   endproperty
   a_high_depth: assert property (p_high_depth)
      else $error("high mode over eight words");

   property p_prime_spacing;
      @(posedge clk_i) disable iff (!rst_n_i)
      state == tpfs_pkg::ST_PRIME && !tx_digital_reset_i &&
      mode != tpfs_pkg::MODE_REG ##1 state == tpfs_pkg::ST_RUN
      |-> $past(count) >= (($past(mode) == tpfs_pkg::MODE_HIGH) ?
                           4'h4 : 4'h2);
   endproperty
   a_prime_spacing: assert property (p_prime_spacing)
      else $error("reads started before spacing");

   sequence s_low_out;
      rd_fire && eff_bser && !tx_digital_reset_i;
   endsequence

   property p_low_first;
      @(posedge clk_i) disable iff (!rst_n_i)
      s_low_out |=> out_o.valid && out_o.data == $past(lo_half);
   endproperty
   a_low_first: assert property (p_low_first)
      else $error("low half not sent first");

   property p_half_rate;
      @(posedge clk_i) disable iff (!rst_n_i)
      eff_bser && $stable(eff_bser) && core_clk_en_o && par_en
      |-> !rd_slot;
   endproperty
   a_half_rate: assert property (p_half_rate)
      else $error("fabric rate not halved");

   property p_dest;
      @(posedge clk_i) disable iff (!rst_n_i)
      (cfg.w10 || cfg.byp) ##1 $stable(cfg) |-> out_o.dest ==
         tpfs_pkg::DEST_SER;
   endproperty
   a_dest: assert property (p_dest)
      else $error("10-bit or bypass data sent to encoder");

   property p_dw_legal;
      @(posedge clk_i) disable iff (!rst_n_i)
      eff_dw |-> cfg.proto == tpfs_pkg::PROTO_BASIC ||
                 cfg.proto == tpfs_pkg::PROTO_DETLAT;
   endproperty
   a_dw_legal: assert property (p_dw_legal)
      else $error("double width with wrong protocol");

   property p_variant;
      @(posedge clk_i) disable iff (!rst_n_i)
      !ALLOW_BSER_DW && eff_dw |-> !eff_bser;
   endproperty
   a_variant: assert property (p_variant)
      else $error("serializer in double width on restricted variant");

endmodule

`default_nettype wire

// *** tpfs_pkg.sv ***
/*
 * Constants, types and register map of the transmit phase compensation
 * FIFO with byte serializer.
 * Assumes one clock; parallel and fabric rates arrive as enable pulses.
 */
`default_nettype none

package tpfs_pkg;

   // Data widths
   localparam int WORD_W = 40;
   localparam int SYM_W = 20;

   // Register byte addresses
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_STAT = 4'h4;
   localparam logic [3:0] REG_MASK = 4'h8;
   localparam logic [3:0] REG_LEVEL = 4'hc;

   // Control field positions and reset value
   localparam int CTRL_PROTO_LSB = 0;
   localparam int CTRL_W10_BIT = 2;
   localparam int CTRL_DW_BIT = 3;
   localparam int CTRL_BSER_BIT = 4;
   localparam int CTRL_ENC_BIT = 5;
   localparam int CTRL_BYP_BIT = 6;
   localparam int CTRL_BOND_BIT = 7;
   localparam int CTRL_CCLK_BIT = 8;
   localparam logic [8:0] CTRL_RST = 9'h000;

   // Status and mask bit positions, reset value
   localparam int ST_OVF_BIT = 0;
   localparam int ST_UNF_BIT = 1;
   localparam int ST_CFG_BIT = 2;
   localparam logic [2:0] STAT_RST = 3'h0;
   localparam logic [2:0] MASK_RST = 3'h0;

   // FIFO depth and start threshold per mode
   localparam logic [3:0] LOW_DEPTH = 4'h4;
   localparam logic [3:0] HIGH_DEPTH = 4'h8;
   localparam logic [3:0] LOW_PRIME = 4'h2;
   localparam logic [3:0] HIGH_PRIME = 4'h4;

   typedef enum logic [1:0] {
      PROTO_BASIC = 2'h0,
      PROTO_DETLAT = 2'h1,
      PROTO_PCIE = 2'h2,
      PROTO_OTHER = 2'h3
   } tpfs_proto_e;

   typedef enum logic [2:0] {
      MODE_LOW = 3'b001,
      MODE_HIGH = 3'b010,
      MODE_REG = 3'b100
   } tpfs_mode_e;

   typedef enum logic [1:0] {
      DEST_SER = 2'b01,
      DEST_ENC = 2'b10
   } tpfs_dest_e;

   typedef enum logic [1:0] {
      ST_PRIME = 2'b01,
      ST_RUN = 2'b10
   } tpfs_state_e;

   typedef struct packed {
      logic cclk;
      logic bond;
      logic byp;
      logic enc;
      logic bser;
      logic dw;
      logic w10;
      tpfs_proto_e proto;
   } tpfs_cfg_s;

   typedef struct packed {
      logic [SYM_W-1:0] data;
      logic valid;
      tpfs_dest_e dest;
   } tpfs_out_s;

endpackage

`default_nettype wire

// *** tpfs_fabric_model.sv ***
/*
 * Fabric-side word source for the transmit FIFO bench.
 * Assumes the block's clock; core-clock rate is set by per_i.
 */
`timescale 1ns/1ps
`default_nettype none

module tpfs_fabric_model (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic clr_i,
   input wire logic cclk_i,
   input wire logic [3:0] per_i,
   input wire logic slot_i,
   output logic core_en_o,
   output logic [39:0] data_o
);
   logic [3:0] pc;
   logic [7:0] k;
   logic wslot;

   // Own enable with core clock, else the block's rate enable
   assign wslot = cclk_i ? core_en_o : slot_i;
   // Distinct bytes so any wrong half or slice shows up
   assign data_o = {k + 8'h04, k + 8'h03, k + 8'h02, k + 8'h01, k};

   // Equal to the read rate unless a fault scenario sets another
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pc <= 4'h0;
         core_en_o <= 1'b0;
      end else if (clr_i || !cclk_i || per_i == 4'h0) begin
         pc <= 4'h0;
         core_en_o <= 1'b0;
      end else begin
         pc <= (pc + 4'h1 == per_i) ? 4'h0 : pc + 4'h1;
         core_en_o <= (pc == 4'h0);
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         k <= 8'h00;
      end else if (clr_i) begin
         k <= 8'h00;
      end else if (wslot) begin
         k <= k + 8'h05;
      end
   end
endmodule

`default_nettype wire

// *** tb_top.sv ***
/*
 * Bench for the transmit phase FIFO and byte serializer.
 * Assumes one 200 MHz clock; the fabric model supplies the words.
 */
`timescale 1ns/1ps
`default_nettype none

module tb_top;
   logic clk = 0, rst_n = 0, dres = 0, lpe = 0, bpe = 0, wr = 0, rd = 0;
   logic [3:0] addr = 4'h0, pper = 4'h0, fper = 4'h0, pc = 4'h0;
   logic [31:0] wdata = 32'h0, rdata, rv;
   logic [39:0] txd;
   logic cen, cce, ferr, irq, fcclk = 0, bond = 0, bser = 0;
   tpfs_pkg::tpfs_out_s out;
   tpfs_pkg::tpfs_dest_e edest;
   logic [19:0] msk;
   logic [39:0] wq [256];
   int wc [256];
   int cyc = 0, wn, rn, nout, skip, ncce, npar, nerr, llo, lhi, hw;
   bit on = 0, ph, sync;
   int miscompares = 0, checks = 0;

   always #2.5 clk = ~clk;

   tpfs_tx_fifo_bser u_tpfs_tx_fifo_bser (.clk_i(clk), .rst_n_i(rst_n),
      .tx_digital_reset_i(dres), .local_par_en_i(lpe),
      .bonded_par_en_i(bpe), .tx_core_en_i(cen), .tx_data_i(txd),
      .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
      .rdata_o(rdata), .out_o(out), .core_clk_en_o(cce),
      .fifo_err_o(ferr), .irq_o(irq));

   tpfs_fabric_model u_tpfs_fabric_model (.clk_i(clk), .rst_n_i(rst_n),
      .clr_i(dres), .cclk_i(fcclk), .per_i(fper), .slot_i(cce),
      .core_en_o(cen), .data_o(txd));

   // Only the enable of the selected clock source toggles
   always @(posedge clk) begin
      pc <= (pper == 4'h0 || pc + 4'h1 == pper) ? 4'h0 : pc + 4'h1;
      lpe <= pper != 4'h0 && pc == 4'h0 && !bond;
      bpe <= pper != 4'h0 && pc == 4'h0 && bond;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic check_out();
      logic [19:0] e;
      int lat;
      e = 20'(ph ? wq[rn] >> hw : wq[rn]) & msk;
      lat = cyc - wc[rn];
      // Stale register contents may lead the first word
      if (!sync && (out.data & msk) !== (wq[0][19:0] & msk)) begin
         skip++;
         if (skip == 4) chk(32'h0, 32'h1);
      end else begin
         sync = 1;
         chk(32'(out.data & msk), 32'(e));
         chk(32'(out.dest), 32'(edest));
         if (!bser) chk(lat >= llo && lat <= lhi, 1);
         if (bser && !ph) ph = 1;
         else begin
            ph = 0;
            rn++;
         end
         nout++;
      end
   endtask

   // Sampled on the falling edge, where everything has settled
   always @(negedge clk) begin
      cyc++;
      nerr += ferr;
      if (on) begin
         if (fcclk ? cen : cce) begin
            wq[wn] = txd;
            wc[wn] = cyc;
            wn++;
         end
         ncce += cce;
         npar += lpe | bpe;
         if (out.valid) check_out();
      end
   end

   task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      @(posedge clk);
   endtask

   task automatic rd_reg(input logic [3:0] a);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      rv = rdata;
      @(posedge clk);
   endtask

   task automatic dreset();
      dres <= 1'b1;
      repeat (2) @(posedge clk);
      dres <= 1'b0;
   endtask

   task automatic stream(input logic [8:0] c, input logic [2:0] m,
                         input int lo, input int hi);
      wr_reg(tpfs_pkg::REG_CTRL, {23'h0, c});
      fcclk <= c[tpfs_pkg::CTRL_CCLK_BIT];
      bond <= c[tpfs_pkg::CTRL_BOND_BIT];
      bser = c[tpfs_pkg::CTRL_BSER_BIT];
      hw = c[3] ? (c[2] ? 20 : 16) : (c[2] ? 10 : 8);
      msk = 20'((64'h1 << hw) - 1);
      edest = (c[5] && !c[6] && !c[2]) ? tpfs_pkg::DEST_ENC
                                       : tpfs_pkg::DEST_SER;
      llo = lo;
      lhi = hi;
      dreset();
      {wn, rn, nout, skip, ncce, npar, nerr, ph, sync} = '0;
      on = 1;
      pper <= 4'h1;
      fper <= 4'h1;
      repeat (60) @(posedge clk);
      pper <= 4'h0;
      fper <= 4'h0;
      on = 0;
      repeat (4) @(posedge clk);
      chk(nout > 20, 1);
      chk(32'(nerr), 32'h0);
      if (bser) chk($unsigned(npar - 2 * ncce + 2) <= 4, 1);
      rd_reg(tpfs_pkg::REG_LEVEL);
      chk(32'(rv[6:4]), 32'(m));
      chk(32'(rv[10:9]), 32'(c[4:3]));
      rd_reg(tpfs_pkg::REG_CTRL);
      chk(rv, {23'h0, c});
   endtask

   task automatic cfgbad(input logic [8:0] c, input logic [1:0] eff);
      wr_reg(tpfs_pkg::REG_CTRL, {23'h0, c});
      rd_reg(tpfs_pkg::REG_STAT);
      chk(32'(rv[2:0]), 32'h4);
      rd_reg(tpfs_pkg::REG_LEVEL);
      chk(32'(rv[10:9]), 32'(eff));
      wr_reg(tpfs_pkg::REG_CTRL, 32'h0);
      wr_reg(tpfs_pkg::REG_STAT, 32'h7);
      rd_reg(tpfs_pkg::REG_STAT);
      chk(rv, 32'h0);
   endtask

   // Rate mismatch on purpose: overflow or underflow
   task automatic fault(input logic [3:0] pp, input logic [3:0] fp,
                        input int b);
      wr_reg(tpfs_pkg::REG_MASK, 32'h0);
      dreset();
      nerr = 0;
      pper <= pp;
      fper <= fp;
      repeat (40) @(posedge clk);
      rd_reg(tpfs_pkg::REG_LEVEL);
      chk(rv[3:0] <= tpfs_pkg::LOW_DEPTH, 1);
      pper <= 4'h0;
      fper <= 4'h0;
      repeat (4) @(posedge clk);
      chk(nerr > 0, 1);
      rd_reg(tpfs_pkg::REG_STAT);
      chk(32'(rv[b]), 32'h1);
      chk(32'(irq), 32'h0);
      wr_reg(tpfs_pkg::REG_MASK, 32'h1 << b);
      repeat (2) @(posedge clk);
      chk(32'(irq), 32'h1);
      wr_reg(tpfs_pkg::REG_STAT, 32'h1 << b);
      repeat (2) @(posedge clk);
      chk(32'(irq), 32'h0);
   endtask

   task automatic test_done();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   initial begin
      #100000;
      miscompares++;
      test_done();
   end

   initial begin
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      rd_reg(tpfs_pkg::REG_CTRL);
      chk(rv, 32'(tpfs_pkg::CTRL_RST));
      rd_reg(tpfs_pkg::REG_STAT);
      chk(rv, 32'(tpfs_pkg::STAT_RST));
      rd_reg(tpfs_pkg::REG_MASK);
      chk(rv, 32'(tpfs_pkg::MASK_RST));
      wr_reg(4'h2, 32'hffff_ffff);
      rd_reg(4'h2);
      chk(rv, 32'h0);
      chk(32'(out.valid), 32'h0);
      // Bench latency equals the number of clock edges through
      stream(9'h107, tpfs_pkg::MODE_LOW, 3, 4);
      stream(9'h027, tpfs_pkg::MODE_LOW, 3, 4);
      stream(9'h022, tpfs_pkg::MODE_HIGH, 5, 6);
      stream(9'h185, tpfs_pkg::MODE_REG, 2, 2);
      stream(9'h014, tpfs_pkg::MODE_LOW, 0, 0);
      stream(9'h030, tpfs_pkg::MODE_LOW, 0, 0);
      stream(9'h06c, tpfs_pkg::MODE_LOW, 3, 4);
      cfgbad(9'h00b, 2'b00);
      cfgbad(9'h018, 2'b01);
      wr_reg(tpfs_pkg::REG_CTRL, 32'h107);
      fcclk <= 1'b1;
      bond <= 1'b0;
      fault(4'h2, 4'h1, tpfs_pkg::ST_OVF_BIT);
      fault(4'h1, 4'h3, tpfs_pkg::ST_UNF_BIT);
      pper <= 4'h2;
      fper <= 4'h1;
      repeat (20) @(posedge clk);
      pper <= 4'h0;
      fper <= 4'h0;
      dreset();
      @(posedge clk);
      rd_reg(tpfs_pkg::REG_STAT);
      chk(32'(rv[1:0]), 32'h0);
      rd_reg(tpfs_pkg::REG_LEVEL);
      chk(32'(rv[3:0]), 32'h0);
      rd_reg(tpfs_pkg::REG_CTRL);
      chk(rv, 32'h107);
      test_done();
   end
endmodule

`default_nettype wire
